// file: src/arfw_result_path.sv
// Result formatting, accumulation and window flag of the SAR converter
//
// Overview of operation
// - Each completed series loads high and low result bytes
// - Justify 000 right, 100 left aligned
// - Single conversion gives a 10-bit unsigned value
// - Unoccupied result bits read as zero
// - Repeat above one presents sum after series
// - Accumulate 4, 8, 16, 32 or 64 samples
// - Repeat codes 0 to 5 select sample count
// - Justify codes 1 to 3 shift sum right
// - Compare result with limits, set window flag
// - Limits are high and low byte pairs
// - Ordered limits match strictly between them
// - Reversed limits match strictly outside them
// - Window flag is interrupt and pollable bit
// - Compare only complete sums, never partials
// - Flag sticks until firmware clears it
// - Factory sensor offset readable as byte pair
`timescale 1ns/1ps
module arfw_result_path
  import arfw_pkg::*;
#(
  parameter logic [15:0] TEMP_OFFSET = 16'h0000  // Factory offset; arbitrary default
)(
  input  wire logic              mclk,                  // System clock, 10 MHz
  input  wire logic              rst,                   // Asynchronous reset, active high
  input  wire logic              conv_done,             // One-cycle pulse: code valid
  input  wire logic [CODE_W-1:0] conv_code,             // Completed conversion code
  input  wire arfw_cfg_t         cfg,                   // Justify and repeat selection
  input  wire logic [7:0]        upper_limit_high_byte, // Greater-than limit, high byte
  input  wire logic [7:0]        upper_limit_low_byte,  // Greater-than limit, low byte
  input  wire logic [7:0]        lower_limit_high_byte, // Less-than limit, high byte
  input  wire logic [7:0]        lower_limit_low_byte,  // Less-than limit, low byte
  input  wire logic              window_flag_clear,     // Firmware clear pulse
  output logic [7:0]             result_high_byte,      // Result word, high byte
  output logic [7:0]             result_low_byte,       // Result word, low byte
  output logic                   result_update,         // Pulse: result just loaded
  output logic                   window_match_flag,     // Sticky window flag
  output logic                   window_irq,            // Window interrupt request
  output logic [7:0]             temp_offset_high_byte, // Sensor offset, high byte
  output logic [7:0]             temp_offset_low_byte   // Sensor offset, low byte
);
  logic [CNT_W-1:0] count;        // Samples taken in current series
  logic [CNT_W-1:0] last_idx;     // Index of the final sample of a series
  logic [RES_W-1:0] acc;          // Running accumulator
  logic [RES_W-1:0] next_acc;     // Accumulator after the incoming sample
  logic [RES_W-1:0] next_result;  // Formatted value about to be loaded
  logic [RES_W-1:0] result;       // Result word
  logic             series_end;   // Incoming sample closes the series
  logic             match;        // Window condition on the new result
  arfw_limits_t     limits;       // Assembled limit words

  // Limit words built from their byte pairs
  assign limits.greater_than_limit = {upper_limit_high_byte, upper_limit_low_byte};
  assign limits.less_than_limit    = {lower_limit_high_byte, lower_limit_low_byte};

  // Repeat count decode; unused codes act as a single conversion
  always_comb begin
    case (cfg.repeat_count_select)
      RPT_1:   last_idx = LAST_1;
      RPT_4:   last_idx = LAST_4;
      RPT_8:   last_idx = LAST_8;
      RPT_16:  last_idx = LAST_16;
      RPT_32:  last_idx = LAST_32;
      RPT_64:  last_idx = LAST_64;
      default: last_idx = LAST_1;
    endcase
  end

  assign series_end = conv_done && (count == last_idx);

  // First sample of a series replaces the old sum; 64 full codes still fit
  always_comb begin
    if (count == '0) begin
      next_acc = {{(RES_W-CODE_W){1'b0}}, conv_code};
    end else begin
      next_acc = acc + {{(RES_W-CODE_W){1'b0}}, conv_code};
    end
  end

  // Justify and shift; shifts fill with zeros so unused bits read zero
  always_comb begin
    case (cfg.shift_justify_select)
      SJ_RIGHT_0: next_result = next_acc;
      SJ_RIGHT_1: next_result = next_acc >> 1;
      SJ_RIGHT_2: next_result = next_acc >> 2;
      SJ_RIGHT_3: next_result = next_acc >> 3;
      SJ_LEFT:    next_result = next_acc << LEFT_SHIFT;
      default:    next_result = next_acc;  // Reserved codes: no shift
    endcase
  end

  // Sample counter within a series
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (series_end) begin
      count <= '0;
    end else if (conv_done) begin
      count <= count + 1'b1;
    end
  end

  // Accumulator follows every sample
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc <= RESULT_RST;
    end else if (conv_done) begin
      acc <= next_acc;
    end
  end

  // Result word loads only when a series closes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result        <= RESULT_RST;
      result_update <= 1'b0;
    end else begin
      result_update <= series_end;
      if (series_end) begin
        result <= next_result;
      end
    end
  end

  assign result_high_byte = result[RES_W-1:BYTE_W];
  assign result_low_byte  = result[BYTE_W-1:0];

  // Comparator sees the value being loaded in this same edge
  arfw_window_cmp u_cmp (
    .mclk   (mclk),
    .rst    (rst),
    .value  (next_result),
    .limits (limits),
    .match  (match)
  );

  // Sticky flag; a new match wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      window_match_flag <= 1'b0;
    end else if (series_end && match) begin
      window_match_flag <= 1'b1;
    end else if (window_flag_clear) begin
      window_match_flag <= 1'b0;
    end
  end

  // Flag is both the polled bit and the interrupt request
  assign window_irq = window_match_flag;

  // Factory sensor offset pair
  assign temp_offset_high_byte = TEMP_OFFSET[RES_W-1:BYTE_W];
  assign temp_offset_low_byte  = TEMP_OFFSET[BYTE_W-1:0];

  // Completion of a whole series
  sequence series_done_s;
    conv_done && (count == last_idx);
  endsequence

  // A sample that does not end the series
  sequence partial_s;
    conv_done && (count != last_idx);
  endsequence

  result_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    !series_end |=> $stable(result))
    else $error("Result changed without a completed series");

  right_format_a: assert property (
    @(posedge mclk) disable iff (rst)
    (series_done_s and (cfg.repeat_count_select == RPT_1 &&
      cfg.shift_justify_select == SJ_RIGHT_0)) |=>
      result == {{(RES_W-CODE_W){1'b0}}, $past(conv_code)})
    else $error("Single right-justified result wrong");

  left_format_a: assert property (
    @(posedge mclk) disable iff (rst)
    (series_done_s and (cfg.repeat_count_select == RPT_1 &&
      cfg.shift_justify_select == SJ_LEFT)) |=>
      result == {$past(conv_code), {LEFT_SHIFT{1'b0}}})
    else $error("Left-justified result wrong");

  no_partial_a: assert property (
    @(posedge mclk) disable iff (rst)
    partial_s |=>
      !result_update && ($stable(window_match_flag) || $past(window_flag_clear)))
    else $error("Partial sum produced an update");

  series_start_a: assert property (
    @(posedge mclk) disable iff (rst)
    (conv_done && count == '0) |=> acc == {{(RES_W-CODE_W){1'b0}}, $past(conv_code)})
    else $error("Accumulator not restarted");

  flag_set_a: assert property (
    @(posedge mclk) disable iff (rst)
    (series_done_s and match) |=> window_match_flag && result_update)
    else $error("Window match did not set flag");

  flag_sticky_a: assert property (
    @(posedge mclk) disable iff (rst)
    (window_match_flag && !window_flag_clear) |=> window_match_flag)
    else $error("Window flag dropped without clear");

  flag_cause_a: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(window_match_flag) |-> $past(series_end && match))
    else $error("Window flag rose without a match");
endmodule : arfw_result_path

// file: src/arfw_pkg.sv
// Shared constants and carrier types for the ADC result format and window compare block
package arfw_pkg;
  localparam int          CODE_W      = 10;        // Converter code width
  localparam int          RES_W       = 16;        // Result and accumulator width
  localparam int          CNT_W       = 6;         // Sample counter width
  localparam int          BYTE_W      = 8;         // Register byte width
  localparam int          LEFT_SHIFT  = 6;         // Left-justify shift for a 10-bit code
  localparam logic [2:0]  SJ_RIGHT_0  = 3'h0;      // Right justified, no shift
  localparam logic [2:0]  SJ_RIGHT_1  = 3'h1;      // Right justified, shift by 1
  localparam logic [2:0]  SJ_RIGHT_2  = 3'h2;      // Right justified, shift by 2
  localparam logic [2:0]  SJ_RIGHT_3  = 3'h3;      // Right justified, shift by 3
  localparam logic [2:0]  SJ_LEFT     = 3'h4;      // Left justified, no shift
  localparam logic [2:0]  RPT_1       = 3'h0;      // One conversion
  localparam logic [2:0]  RPT_4       = 3'h1;      // Four conversions
  localparam logic [2:0]  RPT_8       = 3'h2;      // Eight conversions
  localparam logic [2:0]  RPT_16      = 3'h3;      // Sixteen conversions
  localparam logic [2:0]  RPT_32      = 3'h4;      // Thirty-two conversions
  localparam logic [2:0]  RPT_64      = 3'h5;      // Sixty-four conversions
  localparam logic [5:0]  LAST_1      = 6'h00;     // Last sample index per repeat count
  localparam logic [5:0]  LAST_4      = 6'h03;
  localparam logic [5:0]  LAST_8      = 6'h07;
  localparam logic [5:0]  LAST_16     = 6'h0f;
  localparam logic [5:0]  LAST_32     = 6'h1f;
  localparam logic [5:0]  LAST_64     = 6'h3f;
  localparam logic [15:0] RESULT_RST  = 16'h0000;  // Result pair after reset

  // Format configuration from firmware
  typedef struct packed {
    logic [2:0] shift_justify_select;
    logic [2:0] repeat_count_select;
  } arfw_cfg_t;

  // Window comparator limits
  typedef struct packed {
    logic [15:0] greater_than_limit;
    logic [15:0] less_than_limit;
  } arfw_limits_t;
endpackage : arfw_pkg

// file: src/arfw_window_cmp.sv
// Window comparator: decides whether a result lies in the programmed window
`timescale 1ns/1ps
module arfw_window_cmp
  import arfw_pkg::*;
(
  input  wire logic         mclk,     // Clock, only for the checks
  input  wire logic         rst,      // Reset, only for the checks
  input  wire logic [15:0]  value,    // Result to compare
  input  wire arfw_limits_t limits,   // Greater-than and less-than limits
  output logic              match     // Result meets the window condition
);
  logic above;  // Strictly above the greater-than limit
  logic below;  // Strictly below the less-than limit

  // Inside window when limits are ordered, outside window otherwise
  always_comb begin
    above = value > limits.greater_than_limit;
    below = value < limits.less_than_limit;
    if (limits.greater_than_limit < limits.less_than_limit) begin
      match = above && below;
    end else begin
      match = above || below;
    end
  end

  window_between_a: assert property (
    @(posedge mclk) disable iff (rst)
    (limits.greater_than_limit < limits.less_than_limit && match) |->
      (value > limits.greater_than_limit && value < limits.less_than_limit))
    else $error("Inside window match outside the limits");

  window_outside_a: assert property (
    @(posedge mclk) disable iff (rst)
    (limits.greater_than_limit >= limits.less_than_limit &&
     (value > limits.greater_than_limit || value < limits.less_than_limit)) |-> match)
    else $error("Outside window result missed");
endmodule : arfw_window_cmp

// file: tb/arfw_conv_model.sv
// Converter core model that delivers completed codes on the system clock
`timescale 1ns/1ps
module arfw_conv_model
  import arfw_pkg::*;
(
  input  wire logic         mclk,      // System clock
  output logic              conv_done, // Code valid strobe
  output logic [CODE_W-1:0] conv_code  // Completed code
);
  // Idle strobe low; code lines carry no meaning outside a strobe
  initial begin
    conv_done = 1'b0;
    conv_code = '1;
  end

  // Back-to-back samples; the code lines then show the inverse so stale data is not reused
  task automatic run(input logic [CODE_W-1:0] code, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      conv_done <= 1'b1;
      // Codes are always defined: the source counts as enabled and selected
      conv_code <= code;
    end
    @(posedge mclk);
    conv_done <= 1'b0;
    conv_code <= ~code;
  endtask : run
endmodule : arfw_conv_model

// file: tb/tb_top.sv
// Self-checking bench for the result format and window compare path
`timescale 1ns/1ps
module tb_top;
  import arfw_pkg::*;
  localparam logic [15:0] OFFS = 16'h5a3c; // Sensor offset; value is arbitrary
  logic              mclk, rst, window_flag_clear;  // Clock, reset, flag clear
  logic              conv_done;                     // Strobe from the core model
  logic [CODE_W-1:0] conv_code;                     // Code from the core model
  arfw_cfg_t         cfg;                           // Justify and repeat selection
  logic [7:0]        gt_hi, gt_lo, lt_hi, lt_lo;    // Window limit bytes
  logic [7:0]        res_hi, res_lo, off_hi, off_lo; // Result and offset bytes
  logic              result_update, window_match_flag, window_irq; // Status outputs
  int                err_count = 0;                 // Mismatches seen
  int                n_checks = 0;                  // Comparisons made
  int                upd_cnt = 0;                   // Result update pulses

  arfw_conv_model core (.mclk(mclk), .conv_done(conv_done), .conv_code(conv_code));
  arfw_result_path #(.TEMP_OFFSET(OFFS)) dut (
    .mclk(mclk), .rst(rst), .conv_done(conv_done), .conv_code(conv_code), .cfg(cfg),
    .upper_limit_high_byte(gt_hi), .upper_limit_low_byte(gt_lo),
    .lower_limit_high_byte(lt_hi), .lower_limit_low_byte(lt_lo),
    .window_flag_clear(window_flag_clear), .result_high_byte(res_hi),
    .result_low_byte(res_lo), .result_update(result_update),
    .window_match_flag(window_match_flag), .window_irq(window_irq),
    .temp_offset_high_byte(off_hi), .temp_offset_low_byte(off_lo));

  // Free-running 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Count update pulses seen at each edge
  always @(posedge mclk) begin
    if (result_update === 1'b1) upd_cnt++;
  end

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Program limits as byte pairs
  task automatic set_lim(input logic [15:0] gt, input logic [15:0] lt);
    @(posedge mclk);
    {gt_hi, gt_lo} <= gt;
    {lt_hi, lt_lo} <= lt;
  endtask : set_lim

  // One series: configure, feed n codes, judge result, flag and update count
  task automatic series(input logic [2:0] sj, input logic [2:0] rp, input logic [9:0] code,
                        input int n, input logic [15:0] exp, input logic flag);
    int base;  // Update pulses counted before this series
    @(posedge mclk);
    cfg <= '{shift_justify_select: sj, repeat_count_select: rp};
    base = upd_cnt;
    core.run(code, n);
    #1;
    chk({res_hi, res_lo}, exp);
    chk({15'h0, window_match_flag}, {15'h0, flag});
    chk({15'h0, window_irq}, {15'h0, flag});
    @(posedge mclk);
    #1;
    chk(16'(upd_cnt - base), 16'h0001);
  endtask : series

  // Clear the flag with a one-cycle pulse
  task automatic clr();
    @(posedge mclk);
    window_flag_clear <= 1'b1;
    @(posedge mclk);
    window_flag_clear <= 1'b0;
    #1;
    chk({15'h0, window_match_flag}, 16'h0000);
  endtask : clr

  // Values straight after reset
  task automatic t_reset();
    chk({res_hi, res_lo}, RESULT_RST);
    chk({15'h0, window_match_flag}, 16'h0000);
    chk({off_hi, off_lo}, OFFS);
  endtask : t_reset

  // Single conversions, right and left justified; limits chosen never to match
  task automatic t_format();
    set_lim(16'hffff, 16'h0000);
    series(SJ_RIGHT_0, RPT_1, 10'h3ff, 1, 16'h03ff, 1'b0);
    series(SJ_LEFT, RPT_1, 10'h3ff, 1, 16'hffc0, 1'b0);
    series(SJ_LEFT, RPT_1, 10'h200, 1, 16'h8000, 1'b0);
    series(3'h5, 3'h6, 10'h155, 1, 16'h0155, 1'b0);
    series(SJ_RIGHT_0, 3'h7, 10'h2aa, 1, 16'h02aa, 1'b0);
  endtask : t_format

  // Repeat codes 1 to 5, right justified with a rotating shift
  task automatic t_accum();
    int n;
    for (int r = 1; r <= 5; r++) begin
      n = 4 << (r - 1);
      series(3'((r - 1) % 4), 3'(r), 10'h3ff, n, 16'(32'h3ff * n) >> ((r - 1) % 4), 1'b0);
    end
    series(SJ_RIGHT_0, RPT_4, 10'h001, 4, 16'h0004, 1'b0);
  endtask : t_accum

  // Inside and outside windows, stickiness, partial sums and set winning over clear
  task automatic t_window();
    set_lim(16'h0040, 16'h0080);
    series(SJ_RIGHT_0, RPT_1, 10'h040, 1, 16'h0040, 1'b0);
    series(SJ_RIGHT_0, RPT_1, 10'h041, 1, 16'h0041, 1'b1);
    series(SJ_RIGHT_0, RPT_1, 10'h080, 1, 16'h0080, 1'b1);
    clr();
    series(SJ_RIGHT_0, RPT_1, 10'h07f, 1, 16'h007f, 1'b1);
    clr();
    series(SJ_RIGHT_0, RPT_4, 10'h030, 4, 16'h00c0, 1'b0);
    set_lim(16'h0080, 16'h0040);
    series(SJ_RIGHT_0, RPT_1, 10'h060, 1, 16'h0060, 1'b0);
    series(SJ_RIGHT_0, RPT_1, 10'h081, 1, 16'h0081, 1'b1);
    clr();
    series(SJ_RIGHT_0, RPT_1, 10'h03f, 1, 16'h003f, 1'b1);
    clr();
    series(SJ_RIGHT_0, RPT_1, 10'h080, 1, 16'h0080, 1'b0);
    @(posedge mclk);
    window_flag_clear <= 1'b1;
    series(SJ_RIGHT_0, RPT_1, 10'h000, 1, 16'h0000, 1'b1);
    @(posedge mclk);
    window_flag_clear <= 1'b0;
  endtask : t_window

  // Main sequence
  initial begin
    rst = 1'b1;
    window_flag_clear = 1'b0;
    cfg = '0;
    {gt_hi, gt_lo, lt_hi, lt_lo} = {16'hffff, 16'h0000};
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    @(posedge mclk);
    rst <= 1'b0;
    t_format();
    t_accum();
    t_window();
    end_of_test();
  end
endmodule : tb_top
